//--- hpfm_pkg.sv
package hpfm_pkg;

   // ***********************************************
   // Reset values and sizes
   // ***********************************************
   localparam logic DECODE_MUX_RST   = 1'b1;
   localparam logic DECODE_MATCH_RST = 1'b0;
   localparam logic CFG_SEEN_RST     = 1'b0;
   localparam logic DMA_CFG_RST      = 1'b0;
   localparam logic MATCH_RST        = 1'b0;
   localparam logic PIN_IDLE_RST     = 1'b1;
   localparam int   SYNC_STAGES      = 2;
   localparam int   COM_ADDR_W       = 7;

   // ***********************************************
   // Carriers
   // ***********************************************
   typedef struct packed {
      logic edge_pin_b3;    // Strobe pins to memory write and read strobes
      logic edge_pin_b2;    // Select pin to chain enable out
      logic dma_en_b2;      // DMA pins to bus grant and bus request
      logic port_b_en;      // Port B serial function enabled
      logic hcs_drive;      // Chip-select pin drives decoder result
   } hpfm_ctrl_type;

   typedef struct packed {
      logic match_en;       // Host port address match enable
      logic mux_en;         // Host port decode pin multiplexing
   } hpfm_decode_type;

endpackage : hpfm_pkg

//--- hpfm_sync.sv
`timescale 1ns/10ps
`default_nettype none
module hpfm_sync #(
   parameter int   WIDTH = 1,
   parameter logic RST_V = 1'b1
) (
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // First stage only feeds the second
   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta_q <= {WIDTH{RST_V}};
         sync_q <= {WIDTH{RST_V}};
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;
endmodule : hpfm_sync
`default_nettype wire

//--- hpfm_mux.sv
`timescale 1ns/10ps
`default_nettype none
module hpfm_mux
   import hpfm_pkg::*;
(
   input  wire logic                    clk_i,
   input  wire logic                    sys_rst_i,
   input  wire hpfm_pkg::hpfm_ctrl_type ctrl_i,
   input  wire logic                    decode_wr_i,
   input  wire hpfm_pkg::hpfm_decode_type decode_wdata_i,
   input  wire logic                    sys_cfg_wr_i,
   input  wire logic                    dma_cfg_wr_i,
   input  wire logic [6:0]              com_base_i,
   // Core side
   input  wire logic                    port_c_line_two_out_i,
   input  wire logic                    port_c_line_two_oe_i,
   output logic                         port_c_line_two_o,
   input  wire logic                    memory_write_strobe_n_i,
   input  wire logic                    memory_request_n_i,
   input  wire logic                    memory_read_strobe_n_i,
   input  wire logic                    io_select_one_n_i,
   input  wire logic                    chain_enable_out_i,
   input  wire logic                    refresh_cycle_n_i,
   output logic                         wait_n_o,
   output logic                         chain_enable_in_o,
   input  wire logic                    host_dma_request_one_i,
   input  wire logic                    bus_grant_n_i,
   output logic                         host_dma_ack_one_n_o,
   output logic                         bus_request_n_o,
   output logic                         serial0_carrier_detect_n_o,
   output logic                         serial0_clear_to_send_n_o,
   output logic                         serial0_receive_in_o,
   output logic                         host_read_n_o,
   output logic                         host_write_n_o,
   output logic                         com_match_o,
   // Pins
   input  wire logic                    pin_pc2_i,
   output logic                         pin_pc2_o,
   output logic                         pin_pc2_oe_o,
   output logic                         pin_memory_request_n_o,
   output logic                         pin_io_select_one_n_o,
   input  wire logic                    pin_ha3_i,
   output logic                         pin_ha3_o,
   output logic                         pin_ha3_oe_o,
   input  wire logic                    pin_ha4_i,
   input  wire logic                    pin_ha7_i,
   input  wire logic [3:0]              pin_ha_rest_i,
   output logic                         pin_host_dma_request_one_o,
   output logic                         pin_host_dma_request_one_oe_o,
   input  wire logic                    pin_host_dma_ack_one_n_i,
   input  wire logic                    pin_hrd_i,
   input  wire logic                    pin_hwr_i,
   input  wire logic                    pin_ha1_i,
   input  wire logic                    pin_hcs_i,
   output logic                         pin_hcs_o,
   output logic                         pin_hcs_oe_o
);
   import hpfm_pkg::*;

   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   logic [13:0] raw;
   logic [13:0] syn;
   logic        s_pc2, s_ha3, s_ha4, s_ha7, s_host_dma_ack_one_n, s_hrd, s_hwr, s_ha1, s_hcs;
   logic [3:0]  s_rest;

   assign raw = {pin_pc2_i, pin_ha3_i, pin_ha4_i, pin_ha7_i, pin_host_dma_ack_one_n_i, pin_hrd_i,
                 pin_hwr_i, pin_ha1_i, pin_hcs_i, pin_ha_rest_i, 1'b1};

   hpfm_sync #(.WIDTH(14), .RST_V(PIN_IDLE_RST)) u_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (raw),
      .sync_o    (syn)
   );

   assign {s_pc2, s_ha3, s_ha4, s_ha7, s_host_dma_ack_one_n, s_hrd, s_hwr, s_ha1, s_hcs, s_rest} = syn[13:1];

   // ***********************************************
   // Control state
   // ***********************************************
   logic mux_en_q, mux_en_d, match_en_q, match_en_d;
   logic cfg_seen_q, cfg_seen_d, dma_cfg_q, dma_cfg_d;
   logic match_q, match_d;
   logic [6:0] com_addr;

   // Address bits 9,8,6,5 come from their own pins, 7,4,3 from shared pins
   assign com_addr = {s_rest[3], s_rest[2], s_ha7, s_rest[1], s_rest[0], s_ha4, s_ha3};

   always_comb begin
      mux_en_d   = mux_en_q;
      match_en_d = match_en_q;
      if (decode_wr_i) begin
         mux_en_d   = decode_wdata_i.mux_en;
         match_en_d = decode_wdata_i.match_en;
      end
      cfg_seen_d = cfg_seen_q | sys_cfg_wr_i;
      dma_cfg_d  = dma_cfg_q | dma_cfg_wr_i;
      // Without the shared address pins the compare would see core signals
      match_d    = match_en_q & mux_en_q & (com_addr == com_base_i);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mux_en_q   <= DECODE_MUX_RST;
         match_en_q <= DECODE_MATCH_RST;
         cfg_seen_q <= CFG_SEEN_RST;
         dma_cfg_q  <= DMA_CFG_RST;
         match_q    <= MATCH_RST;
      end else begin
         mux_en_q   <= mux_en_d;
         match_en_q <= match_en_d;
         cfg_seen_q <= cfg_seen_d;
         dma_cfg_q  <= dma_cfg_d;
         match_q    <= match_d;
      end
   end

   assign com_match_o = match_q;

   // ***********************************************
   // Pin selection
   // ***********************************************
   always_comb begin
      pin_pc2_o    = ctrl_i.edge_pin_b3 ? memory_write_strobe_n_i : port_c_line_two_out_i;
      pin_pc2_oe_o = ctrl_i.edge_pin_b3 | port_c_line_two_oe_i;
      pin_memory_request_n_o   = ctrl_i.edge_pin_b3 ? memory_read_strobe_n_i : memory_request_n_i;
      pin_io_select_one_n_o  = ctrl_i.edge_pin_b2 ? chain_enable_out_i : io_select_one_n_i;
      port_c_line_two_o = s_pc2;
      // Host address pins are inputs while mux_en_q is set, else HA3 drives refresh out
      pin_ha3_o         = refresh_cycle_n_i;
      pin_ha3_oe_o      = ~mux_en_q;
      wait_n_o          = mux_en_q ? 1'b1 : s_ha4;
      chain_enable_in_o = mux_en_q ? 1'b1 : s_ha7;
      pin_host_dma_request_one_o    = ctrl_i.dma_en_b2 ? bus_grant_n_i : host_dma_request_one_i;
      pin_host_dma_request_one_oe_o = dma_cfg_q;
      host_dma_ack_one_n_o = ctrl_i.dma_en_b2 ? 1'b1 : s_host_dma_ack_one_n;
      bus_request_n_o      = ctrl_i.dma_en_b2 ? s_host_dma_ack_one_n : 1'b1;
      // Idle-high levels keep the serial receiver quiet when port B is off
      serial0_carrier_detect_n_o = ctrl_i.port_b_en ? s_hrd : 1'b1;
      serial0_clear_to_send_n_o  = ctrl_i.port_b_en ? s_hwr : 1'b1;
      serial0_receive_in_o       = ctrl_i.port_b_en ? s_ha1 : 1'b1;
      pin_hcs_o    = ~match_q;
      pin_hcs_oe_o = ctrl_i.hcs_drive;
      // Chip select from the pin or from the decoder, gated until configured
      host_read_n_o  = ~(cfg_seen_q & ~s_hrd & (ctrl_i.hcs_drive ? match_q : ~s_hcs));
      host_write_n_o = ~(cfg_seen_q & ~s_hwr & (ctrl_i.hcs_drive ? match_q : ~s_hcs));
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   // Matches at the first edge after release, so the disable clause does not kill it
   sequence s_rst_release;
      $fell(sys_rst_i);
   endsequence

   property p_strobes;
      @(posedge clk_i) disable iff (sys_rst_i)
      ctrl_i.edge_pin_b3 |-> (pin_pc2_o == memory_write_strobe_n_i) && pin_pc2_oe_o
                             && (pin_memory_request_n_o == memory_read_strobe_n_i);
   endproperty
   a_strobes: assert property (p_strobes) else $error("strobe pins not selected");

   property p_chain_out;
      @(posedge clk_i) disable iff (sys_rst_i)
      pin_io_select_one_n_o == (ctrl_i.edge_pin_b2 ? chain_enable_out_i : io_select_one_n_i);
   endproperty
   a_chain_out: assert property (p_chain_out) else $error("select pin wrong");

   property p_addr_in;
      @(posedge clk_i) disable iff (sys_rst_i)
      mux_en_q |-> !pin_ha3_oe_o;
   endproperty
   a_addr_in: assert property (p_addr_in) else $error("address pin driven");

   property p_bus_swap;
      @(posedge clk_i) disable iff (sys_rst_i)
      ctrl_i.dma_en_b2 |-> (pin_host_dma_request_one_o == bus_grant_n_i) && host_dma_ack_one_n_o
                           && (bus_request_n_o == $past(s_host_dma_ack_one_n, 1) || bus_request_n_o == s_host_dma_ack_one_n);
   endproperty
   a_bus_swap: assert property (p_bus_swap) else $error("bus grant swap wrong");

   property p_chain_hold;
      @(posedge clk_i) disable iff (sys_rst_i)
      mux_en_q |-> chain_enable_in_o;
   endproperty
   a_chain_hold: assert property (p_chain_hold) else $error("chain input not high");

   property p_wait_hold;
      @(posedge clk_i) disable iff (sys_rst_i)
      mux_en_q |-> wait_n_o;
   endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("wait not held high");

   property p_dma_tri;
      @(posedge clk_i) disable iff (sys_rst_i)
      s_rst_release ##0 !dma_cfg_wr_i [*3] |-> !pin_host_dma_request_one_oe_o;
   endproperty
   a_dma_tri: assert property (p_dma_tri) else $error("request pin driven early");

   property p_serial_gate;
      @(posedge clk_i) disable iff (sys_rst_i)
      !ctrl_i.port_b_en |-> serial0_carrier_detect_n_o && serial0_clear_to_send_n_o && serial0_receive_in_o;
   endproperty
   a_serial_gate: assert property (p_serial_gate) else $error("serial fed while off");

   property p_uart_gate;
      @(posedge clk_i) disable iff (sys_rst_i)
      s_rst_release ##0 !sys_cfg_wr_i [*4] |-> host_read_n_o && host_write_n_o;
   endproperty
   a_uart_gate: assert property (p_uart_gate) else $error("host access before config");

   property p_hcs_out;
      @(posedge clk_i) disable iff (sys_rst_i)
      ctrl_i.hcs_drive |-> pin_hcs_oe_o && (pin_hcs_o == !match_q);
   endproperty
   a_hcs_out: assert property (p_hcs_out) else $error("chip select not driven");

   property p_reset_decode;
      @(posedge clk_i) disable iff (sys_rst_i)
      $past(sys_rst_i) |-> mux_en_q && !match_en_q && !com_match_o;
   endproperty
   a_reset_decode: assert property (p_reset_decode) else $error("decode reset state wrong");

   property p_refresh_out;
      @(posedge clk_i) disable iff (sys_rst_i)
      !mux_en_q |-> pin_ha3_oe_o && (pin_ha3_o == refresh_cycle_n_i);
   endproperty
   a_refresh_out: assert property (p_refresh_out) else $error("refresh pin not driven");

endmodule : hpfm_mux
`default_nettype wire

//--- hpfm_host.sv
`timescale 1ns/10ps
`default_nettype none
// ***********************************************
// Host bus and external pin side
// ***********************************************
module hpfm_host (
   input  wire logic [6:0] addr_i,        // {ha9,ha8,ha7,ha6,ha5,ha4,ha3}
   input  wire logic [5:0] hctl_i,        // {hrd,hwr,ha1,hcs,hdack,pc2}
   input  wire logic       pin_pc2_o,
   input  wire logic       pin_pc2_oe_o,
   input  wire logic       pin_ha3_o,
   input  wire logic       pin_ha3_oe_o,
   input  wire logic       pin_hcs_o,
   input  wire logic       pin_hcs_oe_o,
   output logic            pin_pc2_i,
   output logic            pin_ha3_i,
   output logic            pin_ha4_i,
   output logic            pin_ha7_i,
   output logic [3:0]      pin_ha_rest_i,
   output logic            pin_host_dma_ack_one_n_i,
   output logic            pin_hrd_i,
   output logic            pin_hwr_i,
   output logic            pin_ha1_i,
   output logic            pin_hcs_i
);
   // The far side lets go of a pin the device drives, else the two would fight
   assign pin_ha3_i     = pin_ha3_oe_o ? pin_ha3_o : addr_i[0];
   assign pin_hcs_i     = pin_hcs_oe_o ? pin_hcs_o : hctl_i[2];
   assign pin_pc2_i     = pin_pc2_oe_o ? pin_pc2_o : hctl_i[0];
   assign pin_ha4_i     = addr_i[1];
   assign pin_ha7_i     = addr_i[4];
   assign pin_ha_rest_i = {addr_i[6:5], addr_i[3:2]};
   assign pin_host_dma_ack_one_n_i  = hctl_i[1];
   assign pin_hrd_i     = hctl_i[5];
   assign pin_hwr_i     = hctl_i[4];
   assign pin_ha1_i     = hctl_i[3];
endmodule : hpfm_host
`default_nettype wire

//--- host_pin_function_mux_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR %s exp %0h got %0h", n, e, g); end end
module host_pin_function_mux_tb;
   import hpfm_pkg::*;
   // ***********************************************
   // Stimulus and observed signals
   // ***********************************************
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   hpfm_ctrl_type ctrl_i;
   hpfm_decode_type decode_wdata_i;
   logic decode_wr_i, sys_cfg_wr_i, dma_cfg_wr_i, cfg, dma, men, mux, match, cs;
   logic [6:0] com_base_i, addr_i;
   logic [5:0] hctl_i;
   logic [31:0] r;
   logic port_c_line_two_out_i, port_c_line_two_oe_i, memory_write_strobe_n_i, memory_request_n_i;
   logic memory_read_strobe_n_i, io_select_one_n_i, chain_enable_out_i, refresh_cycle_n_i;
   logic host_dma_request_one_i, bus_grant_n_i;
   wire logic port_c_line_two_o, wait_n_o, chain_enable_in_o, host_dma_ack_one_n_o, bus_request_n_o;
   wire logic serial0_carrier_detect_n_o, serial0_clear_to_send_n_o, serial0_receive_in_o;
   wire logic host_read_n_o, host_write_n_o, com_match_o, pin_pc2_o, pin_pc2_oe_o, pin_memory_request_n_o, pin_io_select_one_n_o;
   wire logic pin_ha3_o, pin_ha3_oe_o, pin_host_dma_request_one_o, pin_host_dma_request_one_oe_o, pin_hcs_o, pin_hcs_oe_o;
   wire logic pin_pc2_i, pin_ha3_i, pin_ha4_i, pin_ha7_i, pin_host_dma_ack_one_n_i, pin_hrd_i, pin_hwr_i, pin_ha1_i, pin_hcs_i;
   wire logic [3:0] pin_ha_rest_i;
   int bad_count = 0;
   int total_checks = 0;

   hpfm_mux dut (.clk_i, .sys_rst_i, .ctrl_i, .decode_wr_i, .decode_wdata_i, .sys_cfg_wr_i, .dma_cfg_wr_i,
      .com_base_i, .port_c_line_two_out_i, .port_c_line_two_oe_i, .port_c_line_two_o, .memory_write_strobe_n_i,
      .memory_request_n_i, .memory_read_strobe_n_i, .io_select_one_n_i, .chain_enable_out_i, .refresh_cycle_n_i,
      .wait_n_o, .chain_enable_in_o, .host_dma_request_one_i, .bus_grant_n_i, .host_dma_ack_one_n_o,
      .bus_request_n_o, .serial0_carrier_detect_n_o, .serial0_clear_to_send_n_o, .serial0_receive_in_o,
      .host_read_n_o, .host_write_n_o, .com_match_o, .pin_pc2_i, .pin_pc2_o, .pin_pc2_oe_o, .pin_memory_request_n_o,
      .pin_io_select_one_n_o, .pin_ha3_i, .pin_ha3_o, .pin_ha3_oe_o, .pin_ha4_i, .pin_ha7_i, .pin_ha_rest_i, .pin_host_dma_request_one_o,
      .pin_host_dma_request_one_oe_o, .pin_host_dma_ack_one_n_i, .pin_hrd_i, .pin_hwr_i, .pin_ha1_i, .pin_hcs_i, .pin_hcs_o, .pin_hcs_oe_o);
   hpfm_host host (.addr_i, .hctl_i, .pin_pc2_o, .pin_pc2_oe_o, .pin_ha3_o, .pin_ha3_oe_o, .pin_hcs_o,
      .pin_hcs_oe_o, .pin_pc2_i, .pin_ha3_i, .pin_ha4_i, .pin_ha7_i, .pin_ha_rest_i, .pin_host_dma_ack_one_n_i, .pin_hrd_i,
      .pin_hwr_i, .pin_ha1_i, .pin_hcs_i);

   always #25 clk_i = ~clk_i;

   task end_of_test();
      if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   // Only valid once pins have been stable long enough for sync plus match plus chip-select loop
   task check_all();
      match = men & mux & (addr_i == com_base_i);
      cs = ctrl_i.hcs_drive ? match : !hctl_i[2];
      `CHK("match", match, com_match_o);
      `CHK("hcs_oe", ctrl_i.hcs_drive, pin_hcs_oe_o);
      if (ctrl_i.hcs_drive) `CHK("hcs", !match, pin_hcs_o);
      `CHK("pc2", ctrl_i.edge_pin_b3 ? memory_write_strobe_n_i : port_c_line_two_out_i, pin_pc2_o);
      `CHK("pc2_oe", ctrl_i.edge_pin_b3 | port_c_line_two_oe_i, pin_pc2_oe_o);
      `CHK("pc2_in", (ctrl_i.edge_pin_b3 | port_c_line_two_oe_i) ? (ctrl_i.edge_pin_b3 ? memory_write_strobe_n_i : port_c_line_two_out_i) : hctl_i[0], port_c_line_two_o);
      `CHK("memory_request_n", ctrl_i.edge_pin_b3 ? memory_read_strobe_n_i : memory_request_n_i, pin_memory_request_n_o);
      `CHK("io_select_one_n", ctrl_i.edge_pin_b2 ? chain_enable_out_i : io_select_one_n_i, pin_io_select_one_n_o);
      `CHK("ha3_oe", !mux, pin_ha3_oe_o);
      if (!mux) `CHK("ha3", refresh_cycle_n_i, pin_ha3_o);
      `CHK("wait", mux ? 1'b1 : addr_i[1], wait_n_o);
      `CHK("chain_in", mux ? 1'b1 : addr_i[4], chain_enable_in_o);
      `CHK("host_dma_request_one_oe", dma, pin_host_dma_request_one_oe_o);
      if (dma) `CHK("host_dma_request_one", ctrl_i.dma_en_b2 ? bus_grant_n_i : host_dma_request_one_i, pin_host_dma_request_one_o);
      if (ctrl_i.dma_en_b2) `CHK("bus_request_n", hctl_i[1], bus_request_n_o)
      else `CHK("host_dma_ack_one_n", hctl_i[1], host_dma_ack_one_n_o);
      `CHK("serial0_carrier_detect_n", ctrl_i.port_b_en ? hctl_i[5] : 1'b1, serial0_carrier_detect_n_o);
      `CHK("serial0_clear_to_send_n", ctrl_i.port_b_en ? hctl_i[4] : 1'b1, serial0_clear_to_send_n_o);
      `CHK("serial0_receive_in", ctrl_i.port_b_en ? hctl_i[3] : 1'b1, serial0_receive_in_o);
      `CHK("hrd", !(cfg & !hctl_i[5] & cs), host_read_n_o);
      `CHK("hwr", !(cfg & !hctl_i[4] & cs), host_write_n_o);
   endtask : check_all

   task rnd_step();
      @(negedge clk_i);
      r = $urandom;
      ctrl_i = r[4:0];
      {port_c_line_two_out_i, port_c_line_two_oe_i, memory_write_strobe_n_i, memory_request_n_i,
         memory_read_strobe_n_i, io_select_one_n_i, chain_enable_out_i, refresh_cycle_n_i,
         host_dma_request_one_i, bus_grant_n_i} = r[14:5];
      com_base_i = r[21:15];
      hctl_i = r[27:22];
      addr_i = r[28] ? com_base_i : ~com_base_i;
      decode_wdata_i = r[30:29];
      decode_wr_i = 1'b1;
      @(negedge clk_i);
      decode_wr_i = 1'b0;
      {men, mux} = decode_wdata_i;
      repeat (6) @(negedge clk_i);
      check_all();
   endtask : rnd_step

   // ***********************************************
   // Sequence
   // ***********************************************
   initial begin
      {ctrl_i, decode_wdata_i, decode_wr_i, sys_cfg_wr_i, dma_cfg_wr_i, com_base_i, addr_i, hctl_i} = '0;
      {port_c_line_two_out_i, port_c_line_two_oe_i, memory_write_strobe_n_i, memory_request_n_i,
         memory_read_strobe_n_i, io_select_one_n_i, chain_enable_out_i, refresh_cycle_n_i,
         host_dma_request_one_i, bus_grant_n_i} = '0;
      {cfg, dma, men, mux} = 4'h1;
      void'($urandom(32'h4789));
      repeat (8) @(negedge clk_i);
      sys_rst_i = 1'b0;
      repeat (3) @(negedge clk_i);
      check_all();
      repeat (30) rnd_step();
      @(negedge clk_i);
      {sys_cfg_wr_i, dma_cfg_wr_i} = 2'h3;
      @(negedge clk_i);
      {sys_cfg_wr_i, dma_cfg_wr_i} = 2'h0;
      {cfg, dma} = 2'h3;
      repeat (30) rnd_step();
      // Address equal to base and host strobes low: a reset must still leave all of it shut
      {ctrl_i, com_base_i, addr_i, hctl_i} = '0;
      sys_rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      sys_rst_i = 1'b0;
      {cfg, dma, men, mux} = 4'h1;
      repeat (3) @(negedge clk_i);
      check_all();
      end_of_test();
   end

   initial begin
      repeat (5000) @(posedge clk_i);
      bad_count++;
      end_of_test();
   end
endmodule : host_pin_function_mux_tb
`default_nettype wire
